// >>> rtl/cplr_pkg.sv
/*
  Constants for the configuration power and lock register bank:
  configuration indices, field positions and reset values.
  Assumes an 8-bit configuration index/data space.
*/
package cplr_pkg;

  // ------------------------------------------------------------
  // Configuration indices
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_FLOPPY_POWER_VALID = 8'h00;
  localparam logic [7:0] IDX_PARALLEL_POWER_MODE_LOCK = 8'h01;
  localparam logic [7:0] IDX_SERIAL_POWER_REG = 8'h02;
  localparam logic [7:0] IDX_LOCKED_LAST = 8'h39;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_FLOPPY_POWER_VALID = 8'h28;
  localparam logic [7:0] RST_PARALLEL_POWER_MODE_LOCK = 8'h9c;
  localparam logic [7:0] RST_INDEX = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FPV_POWER_BIT = 3;
  localparam int FPV_FIXED_ONE_BIT = 5;
  localparam int FPV_VALID_BIT = 7;
  localparam int PPL_POWER_BIT = 2;
  localparam int PPL_MODE_BIT = 3;
  localparam int PPL_FIXED_ONE_BIT = 4;
  localparam int PPL_LOCK_BIT = 7;

endpackage

// >>> rtl/cplr_regs.sv
/*
  Configuration power and lock register bank (floppy power/valid and
  parallel port power/mode/lock), reached by index and data port cycles.
  Assumes the host interface logic on the same clock has already decoded
  the index and data port addresses into one-cycle strobes, and that it
  tells this block whether the device is in the configuration state.
  The hard reset input comes from a pin and is synchronised here.
*/
//
// Functional notes
// - Floppy register only at index 00, config state
// - Floppy register resets to 0x28
// - Floppy bits 0-2 read zero
// - Floppy bit 3 powers floppy controller
// - Floppy bit 5 reads one, 4,6 zero
// - Floppy bit 7 plain flag, reset zero
// - Power bit disables device, not decoding
// - Powered-down device still joins range checks
// - Parallel register only at index 01, config state
// - Parallel register resets to 0x9C
// - Parallel bits 0,1,5,6 zero; 4 one
// - Parallel bit 2 powers parallel port
// - Lock bit zero blocks indices 00-39
// - Lock set again only by reset
// - Serial register only at index 02, config state
// - Index port selects, data port accesses
`timescale 1ns/1ps

module cplr_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hard_rst_n,
  input wire logic i_cfg_state,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_io_is_index,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rvalid,
  output logic o_ext_wr,
  output logic o_ext_rd,
  output logic [7:0] o_ext_index,
  output logic [7:0] o_ext_wdata,
  input wire logic [7:0] i_ext_rdata,
  output logic o_floppy_controller_en,
  output logic o_floppy_pins_en,
  output logic o_floppy_decode_en,
  output logic o_parallel_port_en,
  output logic o_parallel_pins_en,
  output logic o_parallel_decode_en,
  output logic o_parallel_printer_mode,
  output logic o_config_lock_bit
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] config_index_select;
    logic floppy_pwr;
    logic valid_flag;
    logic parallel_pwr;
    logic parallel_mode;
    logic config_lock_bit;
    logic hard_meta;
    logic hard_sync;
    logic [7:0] rdata;
    logic rvalid;
  } cplr_state_t;

  cplr_state_t st;
  cplr_state_t next_st;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // True for indices whose access the lock bit gates
  function automatic logic cplr_lockable(input logic [7:0] idx);
    cplr_lockable = (idx <= cplr_pkg::IDX_LOCKED_LAST);
  endfunction

  function automatic logic [7:0] cplr_floppy_image(input cplr_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[cplr_pkg::FPV_POWER_BIT] = s.floppy_pwr;
    v[cplr_pkg::FPV_FIXED_ONE_BIT] = 1'b1;
    v[cplr_pkg::FPV_VALID_BIT] = s.valid_flag;
    cplr_floppy_image = v;
  endfunction

  function automatic logic [7:0] cplr_parallel_image(input cplr_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[cplr_pkg::PPL_POWER_BIT] = s.parallel_pwr;
    v[cplr_pkg::PPL_MODE_BIT] = s.parallel_mode;
    v[cplr_pkg::PPL_FIXED_ONE_BIT] = 1'b1;
    v[cplr_pkg::PPL_LOCK_BIT] = s.config_lock_bit;
    cplr_parallel_image = v;
  endfunction

  // ------------------------------------------------------------
  // Access qualification
  // ------------------------------------------------------------
  logic data_ok;
  logic data_wr;
  logic data_rd;
  logic idx_wr;
  logic idx_rd;
  logic hit_floppy;
  logic hit_parallel;
  logic hit_ext;

  always_comb begin
    // Locked range takes no writes and reads back zero; indices above it stay open
    data_ok = i_cfg_state && !i_io_is_index &&
      (st.config_lock_bit || !cplr_lockable(st.config_index_select));
    data_wr = data_ok && i_io_wr;
    data_rd = data_ok && i_io_rd;
    idx_wr = i_cfg_state && i_io_is_index && i_io_wr;
    idx_rd = i_cfg_state && i_io_is_index && i_io_rd;
    hit_floppy =
      (st.config_index_select == cplr_pkg::IDX_FLOPPY_POWER_VALID);
    hit_parallel =
      (st.config_index_select == cplr_pkg::IDX_PARALLEL_POWER_MODE_LOCK);
    hit_ext = !hit_floppy && !hit_parallel;
  end

  // Other indices (serial power at 02 and up) live outside this block
  assign o_ext_wr = data_wr && hit_ext;
  assign o_ext_rd = data_rd && hit_ext;
  assign o_ext_index = st.config_index_select;
  // Combinational pass so outside registers see data with the strobe
  assign o_ext_wdata = i_io_wdata;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.hard_meta = i_hard_rst_n;
    next_st.hard_sync = st.hard_meta;
    next_st.rvalid = 1'b0;

    if (idx_wr) begin
      next_st.config_index_select = i_io_wdata;
    end

    // Only writable bits are taken; fixed bits come from the image
    if (data_wr && hit_floppy) begin
      next_st.floppy_pwr = i_io_wdata[cplr_pkg::FPV_POWER_BIT];
      next_st.valid_flag = i_io_wdata[cplr_pkg::FPV_VALID_BIT];
    end

    if (data_wr && hit_parallel) begin
      next_st.parallel_pwr = i_io_wdata[cplr_pkg::PPL_POWER_BIT];
      next_st.parallel_mode = i_io_wdata[cplr_pkg::PPL_MODE_BIT];
      // Software can clear the lock but never set it
      next_st.config_lock_bit =
        st.config_lock_bit & i_io_wdata[cplr_pkg::PPL_LOCK_BIT];
    end

    // Hard reset reopens the lock only; other bits keep their values
    if (!st.hard_sync) begin
      next_st.config_lock_bit = 1'b1;
    end

    if (idx_rd) begin
      next_st.rdata = st.config_index_select;
      next_st.rvalid = 1'b1;
    end else if (data_rd) begin
      next_st.rvalid = 1'b1;
      if (hit_floppy) begin
        next_st.rdata = cplr_floppy_image(st);
      end else if (hit_parallel) begin
        next_st.rdata = cplr_parallel_image(st);
      end else begin
        next_st.rdata = i_ext_rdata;
      end
    end else if (i_cfg_state && !i_io_is_index && i_io_rd) begin
      // Locked read still completes, returning zero
      next_st.rdata = 8'h00;
      next_st.rvalid = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st.config_index_select <= cplr_pkg::RST_INDEX;
      st.floppy_pwr <=
        cplr_pkg::RST_FLOPPY_POWER_VALID[cplr_pkg::FPV_POWER_BIT];
      st.valid_flag <=
        cplr_pkg::RST_FLOPPY_POWER_VALID[cplr_pkg::FPV_VALID_BIT];
      st.parallel_pwr <=
        cplr_pkg::RST_PARALLEL_POWER_MODE_LOCK[cplr_pkg::PPL_POWER_BIT];
      st.parallel_mode <=
        cplr_pkg::RST_PARALLEL_POWER_MODE_LOCK[cplr_pkg::PPL_MODE_BIT];
      st.config_lock_bit <=
        cplr_pkg::RST_PARALLEL_POWER_MODE_LOCK[cplr_pkg::PPL_LOCK_BIT];
      st.hard_meta <= 1'b1;
      st.hard_sync <= 1'b1;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Device controls
  // ------------------------------------------------------------
  // Power bits gate device and pins; address decode stays live so a
  // powered-down device still takes part in range checking. Removing
  // it from decode is left to software moving its base below 100h.
  assign o_floppy_controller_en = st.floppy_pwr;
  assign o_floppy_pins_en = st.floppy_pwr;
  assign o_floppy_decode_en = 1'b1;
  assign o_parallel_port_en = st.parallel_pwr;
  assign o_parallel_pins_en = st.parallel_pwr;
  assign o_parallel_decode_en = 1'b1;
  assign o_parallel_printer_mode = st.parallel_mode;
  assign o_config_lock_bit = st.config_lock_bit;
  assign o_io_rdata = st.rdata;
  assign o_io_rvalid = st.rvalid;

endmodule

// >>> tb/cplr_regs_sva.sv
/* Checker for the config power/lock bank, bound to cplr_regs.
   Assumes one clock and the synchronous core reset. */
`timescale 1ns/1ps
module cplr_regs_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hard_rst_n,
  input wire logic i_cfg_state,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_io_is_index,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_rvalid,
  input wire logic o_ext_wr,
  input wire logic o_ext_rd,
  input wire logic [7:0] o_ext_index,
  input wire logic [7:0] o_ext_wdata,
  input wire logic o_floppy_controller_en,
  input wire logic o_floppy_pins_en,
  input wire logic o_floppy_decode_en,
  input wire logic o_parallel_port_en,
  input wire logic o_parallel_pins_en,
  input wire logic o_parallel_decode_en,
  input wire logic o_config_lock_bit
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------
  // Steps
  // ------
  sequence hard_held;
    (!i_hard_rst_n)[*3];
  endsequence
  sequence data_wr(logic [7:0] idx);
    i_cfg_state && i_io_wr && !i_io_is_index && o_ext_index == idx;
  endsequence
  read_answer_a: assert property (i_cfg_state && i_io_rd
    |=> o_io_rvalid) else $error("read not answered");
  stray_answer_a: assert property (!(i_cfg_state && i_io_rd)
    |=> !o_io_rvalid) else $error("answer without read");
  power_gating_a: assert property (
    o_parallel_pins_en == o_parallel_port_en
    && o_floppy_pins_en == o_floppy_controller_en)
    else $error("pins gating wrong");
  decode_live_a: assert property (o_floppy_decode_en
    && o_parallel_decode_en) else $error("decode gated by power");
  floppy_power_a: assert property (data_wr(8'h00) ##0 o_config_lock_bit
    |=> o_floppy_controller_en == $past(i_io_wdata[3])) else $error("floppy");
  parallel_power_a: assert property (
    data_wr(8'h01) ##0 o_config_lock_bit
    |=> o_parallel_port_en == $past(i_io_wdata[2])) else $error("parallel");
  locked_write_a: assert property (data_wr(8'h00) ##0 !o_config_lock_bit
    |=> $stable(o_floppy_controller_en)) else $error("locked write took");
  locked_read_a: assert property (
    i_cfg_state && i_io_rd && !i_io_is_index
    && !o_config_lock_bit && o_ext_index <= 8'h39 |=> o_io_rdata == 8'h00)
    else $error("locked read leaked");
  lock_sticky_a: assert property (!o_config_lock_bit && i_hard_rst_n
    && $past(i_hard_rst_n) && $past(i_hard_rst_n, 2)
    && $past(i_hard_rst_n, 3) |=> !o_config_lock_bit) else $error("relocked");
  hard_unlock_a: assert property (hard_held |=> o_config_lock_bit)
    else $error("hard reset kept lock");
  ext_write_a: assert property (
    data_wr(8'h02) ##0 o_config_lock_bit
    |-> o_ext_wr && o_ext_wdata == i_io_wdata) else $error("ext write lost");
  ext_quiet_a: assert property (o_ext_wr || o_ext_rd
    |-> i_cfg_state && !i_io_is_index && o_ext_index > 8'h01
    && (o_config_lock_bit || o_ext_index > 8'h39))
    else $error("stray ext strobe");
endmodule
bind cplr_regs cplr_regs_sva chk_u (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_hard_rst_n(i_hard_rst_n),
  .i_cfg_state(i_cfg_state),
  .i_io_wr(i_io_wr),
  .i_io_rd(i_io_rd),
  .i_io_is_index(i_io_is_index),
  .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata),
  .o_io_rvalid(o_io_rvalid),
  .o_ext_wr(o_ext_wr),
  .o_ext_rd(o_ext_rd),
  .o_ext_index(o_ext_index),
  .o_ext_wdata(o_ext_wdata),
  .o_floppy_controller_en(o_floppy_controller_en),
  .o_floppy_pins_en(o_floppy_pins_en),
  .o_floppy_decode_en(o_floppy_decode_en),
  .o_parallel_port_en(o_parallel_port_en),
  .o_parallel_pins_en(o_parallel_pins_en),
  .o_parallel_decode_en(o_parallel_decode_en),
  .o_config_lock_bit(o_config_lock_bit)
);

// >>> tb/cplr_host_model.sv
/* Host model issuing index and data port cycles.
   Assumes the bank samples strobes on the rising edge. */
`timescale 1ns/1ps
module cplr_host_model (
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic o_is_index = 1'b0,
  output logic [7:0] o_wdata = 8'h00
);
  // Data scrambled once released so stale values never pass
  task automatic cyc(input logic w, input logic ix, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_is_index <= ix;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic get(input logic ix, output logic [7:0] q, output logic ok);
    cyc(1'b0, ix, 8'h00);
    ok = 1'b0;
    q = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk);
      ok = (i_rvalid === 1'b1);
      q = i_rdata;
    end
  endtask
endmodule

// >>> tb/tb_top.sv
/* Bench for the config power/lock bank: a table of port cycles.
   Assumes the host model; the bench plays the outside registers. */
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_n = 1'b0, i_hard_rst_n = 1'b1, i_cfg_state = 1'b1;
  logic wr, rd, ix, rvalid, fl_en, pp_en, pr_mode, lock, ok;
  logic fl_pin, pp_pin, fl_dec, pp_dec, ext_rd;
  logic [7:0] wd, rdata, ext_index, q;
  int failures = 0;
  int samples_checked = 0;
  // Op nibble: 0 write, 1 read, 2 flags, 3 config state, 4 hard, 5 index,
  // 6 core reset; flags are pins, decodes, enables, mode, lock
  logic [19:0] ops [$] = '{20'h1_00_28, 20'h1_01_9c, 20'h2_00_ff,
    20'h0_00_ff, 20'h1_00_a8, 20'h0_00_00, 20'h1_00_20,
    20'h2_00_77, 20'h0_01_e3, 20'h1_01_90, 20'h2_00_31,
    20'h0_01_ff, 20'h1_01_9c, 20'h3_00_00, 20'h0_00_88,
    20'h3_00_01, 20'h5_00_01, 20'h1_00_20, 20'h1_02_3e,
    20'h0_02_55, 20'h0_01_1c, 20'h1_00_00, 20'h0_00_88,
    20'h0_01_9c, 20'h2_00_76, 20'h1_40_7c, 20'h4_00_00,
    20'h1_01_9c, 20'h1_00_20, 20'h0_00_80, 20'h1_00_a0,
    20'h0_01_00, 20'h2_00_30, 20'h6_00_00, 20'h5_00_00,
    20'h1_00_28, 20'h1_01_9c, 20'h2_00_ff};
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  cplr_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_hard_rst_n(i_hard_rst_n), .i_cfg_state(i_cfg_state),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_is_index(ix), .i_io_wdata(wd),
    .o_io_rdata(rdata), .o_io_rvalid(rvalid), .o_ext_wr(), .o_ext_rd(ext_rd),
    .o_ext_index(ext_index), .o_ext_wdata(),
    .i_ext_rdata(ext_rd ? (ext_index ^ 8'h3c) : 8'h00),
    .o_floppy_controller_en(fl_en),
    .o_floppy_pins_en(fl_pin), .o_floppy_decode_en(fl_dec),
    .o_parallel_port_en(pp_en),
    .o_parallel_pins_en(pp_pin), .o_parallel_decode_en(pp_dec),
    .o_parallel_printer_mode(pr_mode), .o_config_lock_bit(lock));
  cplr_host_model host_u (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_is_index(ix), .o_wdata(wd));
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    samples_checked++;
    if (got !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic rchk(input logic ixp, input logic [7:0] idx,
    input logic [7:0] e);
    if (!ixp)
      host_u.cyc(1'b1, 1'b1, idx);
    host_u.get(ixp, q, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end else
      chk(q, e);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (ops[i]) begin
      case (ops[i][19:16])
        4'h0: begin
          host_u.cyc(1'b1, 1'b1, ops[i][15:8]);
          host_u.cyc(1'b1, 1'b0, ops[i][7:0]);
        end
        4'h1: rchk(1'b0, ops[i][15:8], ops[i][7:0]);
        4'h2: begin
          @(posedge i_clk);
          chk({fl_pin, pp_pin, fl_dec, pp_dec, fl_en, pp_en, pr_mode, lock},
            ops[i][7:0]);
        end
        4'h3: @(posedge i_clk) i_cfg_state <= ops[i][0];
        4'h4: begin
          @(posedge i_clk) i_hard_rst_n <= 1'b0;
          repeat (4) @(posedge i_clk);
          i_hard_rst_n <= 1'b1;
        end
        4'h6: begin
          @(posedge i_clk) i_rst_n <= 1'b0;
          repeat (3) @(posedge i_clk);
          i_rst_n <= 1'b1;
        end
        default: rchk(1'b1, 8'h00, ops[i][7:0]);
      endcase
    end
    wrap_up();
  end
endmodule
